// file: design/adc_cal_control.sv
// Calibration control block: AXI4-Lite registers, oscillator tuning, sequencer and interrupts
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"
module adc_cal_control #(
  parameter int SETTLE_UNIT = 16,
  parameter int FG_CYCLES = 1024,
  parameter int OFFSET_CYCLES = 256,
  parameter int DIG_DIV = 4,
  parameter int LINK_DIV = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [9:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [9:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Oscillator side
  input wire logic oscAboveTarget,
  output logic [6:0] oscTrim,
  // Calibration controls
  output logic calInReset,
  output logic calValuesReset,
  output logic fgCalRun,
  output logic fgOffsetRun,
  output logic bgCalRun,
  output logic bgOffsetRun,
  // Divided clock enables and link
  output logic digClkEn,
  output logic linkClkEn,
  output logic serialLinkEnable,
  // Interrupt
  output logic irq
);
  // Register file
  logic [7:0] oscTrim_reg, pllReset_reg, oscCtrl_reg, calEnable_reg;
  logic [7:0] calCfg0_reg, calCfg1_reg, linkEnable_reg, irqStatus_reg, irqMask_reg;
  // Write channel holding state
  logic awHeld_reg, wHeld_reg, bvalid_reg;
  logic [7:0] awIdx_reg;
  logic [7:0] wData_reg;
  logic wLane0_reg;
  logic [1:0] bresp_reg;
  // Read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rIdx_reg;
  // Engine and sequencer wires
  logic engLoad, engBusy, oscFinished, fgPassDone;
  logic [6:0] engTrim;
  logic oscFinishedDly_reg;

  // Field decode
  wire calEnable = calEnable_reg[`BIT_CAL_ENABLE];
  wire fgEnable = calCfg0_reg[`BIT_FG];
  wire bgEnable = calCfg0_reg[`BIT_BG];
  wire fgOffsetEnable = calCfg0_reg[`BIT_FG_OFFSET];
  wire bgOffsetEnable = calCfg0_reg[`BIT_BG_OFFSET];
  wire oscTuneEnable = oscCtrl_reg[`BIT_OSC_ENABLE];
  wire pllTuneReset = pllReset_reg[`BIT_PLL_RESET];
  wire [2:0] settleCode = oscCtrl_reg[`SETTLE_MSB:`SETTLE_LSB];
  wire [7:0] oscStatus = {7'h00, oscFinished};

  // Write decode
  wire wrFire = awHeld_reg && wHeld_reg && !bvalid_reg;
  wire wrEn = wrFire && wLane0_reg;
  wire wrTrim = wrEn && (awIdx_reg == `IDX_OSC_TRIM);
  wire wrPllReset = wrEn && (awIdx_reg == `IDX_PLL_RESET);
  wire wrOscCtrl = wrEn && (awIdx_reg == `IDX_OSC_CTRL);
  wire wrCalEnable = wrEn && (awIdx_reg == `IDX_CAL_ENABLE);
  wire wrCfg0 = wrEn && (awIdx_reg == `IDX_CALIBRATION_CONFIG_0);
  wire wrCfg1 = wrEn && (awIdx_reg == `IDX_CALIBRATION_CONFIG_1);
  wire wrLink = wrEn && (awIdx_reg == `IDX_LINK_ENABLE);
  wire wrIrqStatus = wrEn && (awIdx_reg == `IDX_IRQ_STATUS);
  wire wrIrqMask = wrEn && (awIdx_reg == `IDX_IRQ_MASK);
  wire wrMapped = (awIdx_reg == `IDX_OSC_TRIM) || (awIdx_reg == `IDX_PLL_RESET) ||
                  (awIdx_reg == `IDX_OSC_CTRL) || (awIdx_reg == `IDX_OSC_STATUS) ||
                  (awIdx_reg == `IDX_CAL_ENABLE) || (awIdx_reg == `IDX_CALIBRATION_CONFIG_0) ||
                  (awIdx_reg == `IDX_CALIBRATION_CONFIG_1) || (awIdx_reg == `IDX_LINK_ENABLE) ||
                  (awIdx_reg == `IDX_IRQ_STATUS) || (awIdx_reg == `IDX_IRQ_MASK);

  // Read decode
  wire [7:0] arIdx = araddr[9:2];
  wire arTake = arvalid && !rvalid_reg;
  wire rdHit = (arIdx == `IDX_OSC_TRIM) || (arIdx == `IDX_PLL_RESET) || (arIdx == `IDX_OSC_CTRL) ||
               (arIdx == `IDX_OSC_STATUS) || (arIdx == `IDX_CAL_ENABLE) || (arIdx == `IDX_CALIBRATION_CONFIG_0) ||
               (arIdx == `IDX_CALIBRATION_CONFIG_1) || (arIdx == `IDX_LINK_ENABLE) || (arIdx == `IDX_IRQ_STATUS) ||
               (arIdx == `IDX_IRQ_MASK);
  wire [7:0] rdByte =
    (arIdx == `IDX_OSC_TRIM) ? oscTrim_reg :
    (arIdx == `IDX_PLL_RESET) ? pllReset_reg :
    (arIdx == `IDX_OSC_CTRL) ? oscCtrl_reg :
    (arIdx == `IDX_OSC_STATUS) ? oscStatus :
    (arIdx == `IDX_CAL_ENABLE) ? calEnable_reg :
    (arIdx == `IDX_CALIBRATION_CONFIG_0) ? calCfg0_reg :
    (arIdx == `IDX_CALIBRATION_CONFIG_1) ? calCfg1_reg :
    (arIdx == `IDX_LINK_ENABLE) ? linkEnable_reg :
    (arIdx == `IDX_IRQ_STATUS) ? irqStatus_reg :
    (arIdx == `IDX_IRQ_MASK) ? irqMask_reg : 8'h00;

  // Bus handshakes
  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready = !wHeld_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awIdx_reg <= 8'h00;
      wData_reg <= 8'h00;
      wLane0_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awIdx_reg <= awaddr[9:2];
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata[7:0];
        wLane0_reg <= wstrb[0];
      end
      if (wrFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
      rIdx_reg <= 8'h00;
    end else if (arTake) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rdByte};
      rresp_reg <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
      rIdx_reg <= arIdx;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control registers; reserved bits store what software writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pllReset_reg <= `RST_PLL_RESET;
      oscCtrl_reg <= `RST_OSC_CTRL;
      calEnable_reg <= `RST_CAL_ENABLE;
      calCfg0_reg <= `RST_CALIBRATION_CONFIG_0;
      calCfg1_reg <= `RST_CALIBRATION_CONFIG_1;
      linkEnable_reg <= `RST_LINK_ENABLE;
      irqMask_reg <= `RST_IRQ;
    end else begin
      if (wrPllReset) pllReset_reg <= wData_reg;
      if (wrOscCtrl) oscCtrl_reg <= wData_reg;
      if (wrCalEnable) calEnable_reg <= wData_reg;
      if (wrCfg0) calCfg0_reg <= wData_reg;
      if (wrCfg1) calCfg1_reg <= wData_reg;
      if (wrLink) linkEnable_reg <= wData_reg;
      if (wrIrqMask) irqMask_reg <= wData_reg;
    end
  end

  // Engine owns the trim while tuning; a software write then is lost
  always_ff @(posedge clk_sys) begin
    if (srst) oscTrim_reg <= `RST_OSC_TRIM;
    else if (engLoad) oscTrim_reg <= {1'b0, engTrim};
    else if (wrTrim && !engBusy) oscTrim_reg <= wData_reg;
  end
  assign oscTrim = oscTrim_reg[`TRIM_MSB:0];
  assign serialLinkEnable = linkEnable_reg[`BIT_LINK_ENABLE];

  osc_tune_engine #(
    .SETTLE_UNIT(SETTLE_UNIT)
  ) uOscTune (
    .clk_sys(clk_sys),
    .srst(srst),
    .tuneReset(pllTuneReset),
    .tuneEnable(oscTuneEnable),
    .settleCode(settleCode),
    .oscAboveTarget(oscAboveTarget),
    .trimLoad(engLoad),
    .trimValue(engTrim),
    .busy(engBusy),
    .finished(oscFinished)
  );

  cal_sequencer #(
    .FG_CYCLES(FG_CYCLES),
    .OFFSET_CYCLES(OFFSET_CYCLES),
    .DIG_DIV(DIG_DIV),
    .LINK_DIV(LINK_DIV)
  ) uSeq (
    .clk_sys(clk_sys),
    .srst(srst),
    .calEnable(calEnable),
    .fgEnable(fgEnable),
    .bgEnable(bgEnable),
    .fgOffsetEnable(fgOffsetEnable),
    .bgOffsetEnable(bgOffsetEnable),
    .calInReset(calInReset),
    .calValuesReset(calValuesReset),
    .fgCalRun(fgCalRun),
    .fgOffsetRun(fgOffsetRun),
    .bgCalRun(bgCalRun),
    .bgOffsetRun(bgOffsetRun),
    .fgPassDone(fgPassDone),
    .digClkEn(digClkEn),
    .linkClkEn(linkClkEn)
  );

  // Sticky interrupt status; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (srst) oscFinishedDly_reg <= 1'b0;
    else oscFinishedDly_reg <= oscFinished;
  end
  wire [7:0] irqEvent = {6'h00, fgPassDone, oscFinished && !oscFinishedDly_reg};
  localparam logic [7:0] IRQ_RESET = `RST_IRQ;
  for (genvar b = 0; b < 8; b++) begin : gIrq
    logic flag_reg;
    always_ff @(posedge clk_sys) begin
      if (srst) flag_reg <= IRQ_RESET[b];
      else if (irqEvent[b]) flag_reg <= 1'b1;
      else if (wrIrqStatus && wData_reg[b]) flag_reg <= 1'b0;
    end
    assign irqStatus_reg[b] = flag_reg;
  end
  assign irq = |(irqStatus_reg & irqMask_reg);

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_done_bypass;
    $fell(pllTuneReset) && !oscTuneEnable |-> ##[1:2] oscFinished;
  endproperty
  a_done_bypass: assert property (p_done_bypass) else $error("finished not set on bypass");

  property p_tune_start;
    $fell(pllTuneReset) && oscTuneEnable |-> ##[1:2] engBusy ##0 !oscFinished;
  endproperty
  a_tune_start: assert property (p_tune_start) else $error("tuning did not start");

  property p_status_reserved;
    $rose(rvalid) && (rIdx_reg == `IDX_OSC_STATUS) |-> (rdata[31:1] == 31'h0) && (rdata[0] == $past(oscFinished));
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits set");

  property p_hold;
    !calEnable |=> calInReset && !fgCalRun && !bgCalRun;
  endproperty
  a_hold: assert property (p_hold) else $error("calibration not held");

  property p_run;
    $rose(calEnable) |=> ##1 !calInReset;
  endproperty
  a_run: assert property (p_run) else $error("calibration not released");

  // Divider restarts from zero, so the first pulse comes DIG_DIV - 1 cycles after enable
  localparam int DIG_FIRST = DIG_DIV - 1;
  property p_div_reset;
    !calEnable ##1 calEnable |-> !digClkEn && !linkClkEn ##DIG_FIRST digClkEn;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider ran in reset");

  property p_fg_select;
    calValuesReset && calEnable |=> (fgCalRun == $past(fgEnable)) && (bgCalRun == ($past(!fgEnable) && bgEnable));
  endproperty
  a_fg_select: assert property (p_fg_select) else $error("foreground selection wrong");

  property p_bg_enable;
    bgCalRun |-> bgEnable && !fgCalRun && !calInReset;
  endproperty
  a_bg_enable: assert property (p_bg_enable) else $error("background ran disabled");

  property p_fg_offset;
    $rose(fgOffsetRun) |-> fgOffsetEnable && fgEnable && $past(fgCalRun);
  endproperty
  a_fg_offset: assert property (p_fg_offset) else $error("foreground offset misordered");

  property p_bg_offset;
    bgOffsetRun |-> bgOffsetEnable && bgCalRun;
  endproperty
  a_bg_offset: assert property (p_bg_offset) else $error("background offset without background");

  c_tune_done: cover property (engBusy ##[1:1000] oscFinished);
  c_fg_offset: cover property (fgOffsetRun ##1 bgOffsetRun);
  c_irq: cover property ($rose(irq));
endmodule

// file: design/cal_ctrl_map.svh
// Register indices, field positions, reset values and defaults of the calibration control block
`ifndef CAL_CTRL_MAP_SVH
`define CAL_CTRL_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_OSC_TRIM 8'h59
`define IDX_PLL_RESET 8'h5c
`define IDX_OSC_CTRL 8'h5d
`define IDX_OSC_STATUS 8'h5e
`define IDX_CAL_ENABLE 8'h61
`define IDX_CALIBRATION_CONFIG_0 8'h62
`define IDX_CALIBRATION_CONFIG_1 8'h65
`define IDX_LINK_ENABLE 8'h70
`define IDX_IRQ_STATUS 8'h71
`define IDX_IRQ_MASK 8'h72
// Reset values
`define RST_OSC_TRIM 8'h00
`define RST_PLL_RESET 8'h00
`define RST_OSC_CTRL 8'h40
`define RST_CAL_ENABLE 8'h01
`define RST_CALIBRATION_CONFIG_0 8'h01
`define RST_CALIBRATION_CONFIG_1 8'h01
`define RST_LINK_ENABLE 8'h00
`define RST_IRQ 8'h00
// Field positions
`define BIT_CAL_ENABLE 0
`define BIT_FG 0
`define BIT_BG 1
`define BIT_FG_OFFSET 2
`define BIT_BG_OFFSET 3
`define BIT_OSC_FINISHED 0
`define BIT_OSC_ENABLE 0
`define BIT_PLL_RESET 0
`define BIT_LINK_ENABLE 0
`define SETTLE_LSB 4
`define SETTLE_MSB 6
`define TRIM_MSB 6
`define IRQ_OSC_DONE 0
`define IRQ_FG_DONE 1
`define TRIM_FIRST_TRIAL 7'h40
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/cal_ctrl_pkg.sv
// Types shared by the calibration control modules
package cal_ctrl_pkg;
  typedef enum logic [1:0] {OSC_IDLE, OSC_STEP, OSC_SETTLE, OSC_DONE} osc_state_t;
  typedef enum logic [2:0] {CAL_HOLD, CAL_RESET_VALUES, CAL_FOREGROUND, FOREGROUND_ENABLE_OFFSET, CAL_RUNNING} cal_state_t;
endpackage

// file: design/cal_sequencer.sv
// Calibration pass sequencer and the clock dividers it holds in reset
`timescale 1ns/1ps
module cal_sequencer #(
  parameter int FG_CYCLES = 1024,
  parameter int OFFSET_CYCLES = 256,
  parameter int DIG_DIV = 4,
  parameter int LINK_DIV = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration
  input wire logic calEnable,
  input wire logic fgEnable,
  input wire logic bgEnable,
  input wire logic fgOffsetEnable,
  input wire logic bgOffsetEnable,
  // Calibration controls
  output logic calInReset,
  output logic calValuesReset,
  output logic fgCalRun,
  output logic fgOffsetRun,
  output logic bgCalRun,
  output logic bgOffsetRun,
  output logic fgPassDone,
  // Divided clock enables
  output logic digClkEn,
  output logic linkClkEn
);
  cal_ctrl_pkg::cal_state_t state_reg, state_next;
  logic [15:0] count_reg;
  wire fgEnd = (count_reg >= 16'(FG_CYCLES - 1));
  wire osEnd = (count_reg >= 16'(OFFSET_CYCLES - 1));
  localparam int DIVS [2] = '{DIG_DIV, LINK_DIV};
  logic [1:0] divPulse;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cal_ctrl_pkg::CAL_HOLD: state_next = cal_ctrl_pkg::CAL_RESET_VALUES;
      cal_ctrl_pkg::CAL_RESET_VALUES: begin
        state_next = fgEnable ? cal_ctrl_pkg::CAL_FOREGROUND : cal_ctrl_pkg::CAL_RUNNING;
      end
      cal_ctrl_pkg::CAL_FOREGROUND: begin
        if (fgEnd) state_next = fgOffsetEnable ? cal_ctrl_pkg::FOREGROUND_ENABLE_OFFSET : cal_ctrl_pkg::CAL_RUNNING;
      end
      cal_ctrl_pkg::FOREGROUND_ENABLE_OFFSET: if (osEnd) state_next = cal_ctrl_pkg::CAL_RUNNING;
      cal_ctrl_pkg::CAL_RUNNING: state_next = cal_ctrl_pkg::CAL_RUNNING;
    endcase
    if (!calEnable) state_next = cal_ctrl_pkg::CAL_HOLD;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= cal_ctrl_pkg::CAL_HOLD;
      count_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      count_reg <= (state_next == state_reg) ? count_reg + 16'h0001 : 16'h0000;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gDiv
    logic [7:0] div_reg;
    always_ff @(posedge clk_sys) begin
      if (srst || !calEnable) div_reg <= 8'h00;
      else div_reg <= (div_reg >= 8'(DIVS[g] - 1)) ? 8'h00 : div_reg + 8'h01;
    end
    assign divPulse[g] = calEnable && (div_reg == 8'(DIVS[g] - 1));
  end

  assign digClkEn = divPulse[0];
  assign linkClkEn = divPulse[1];
  assign calInReset = (state_reg == cal_ctrl_pkg::CAL_HOLD);
  assign calValuesReset = (state_reg == cal_ctrl_pkg::CAL_RESET_VALUES);
  assign fgCalRun = (state_reg == cal_ctrl_pkg::CAL_FOREGROUND);
  assign fgOffsetRun = (state_reg == cal_ctrl_pkg::FOREGROUND_ENABLE_OFFSET);
  assign bgCalRun = (state_reg == cal_ctrl_pkg::CAL_RUNNING) && bgEnable;
  assign bgOffsetRun = bgCalRun && bgOffsetEnable;
  assign fgPassDone = (state_reg != cal_ctrl_pkg::CAL_RUNNING) && (state_reg != cal_ctrl_pkg::CAL_HOLD) &&
                      (state_next == cal_ctrl_pkg::CAL_RUNNING);
endmodule

// file: design/osc_tune_engine.sv
// Successive approximation engine that centres the oscillator frequency trim
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"
module osc_tune_engine #(
  parameter int SETTLE_UNIT = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  input wire logic tuneReset,
  input wire logic tuneEnable,
  input wire logic [2:0] settleCode,
  input wire logic oscAboveTarget,
  // Results
  output logic trimLoad,
  output logic [6:0] trimValue,
  output logic busy,
  output logic finished
);
  cal_ctrl_pkg::osc_state_t state_reg, state_next;
  logic [6:0] trial_reg;
  logic [2:0] bitIdx_reg;
  logic [15:0] settle_reg;
  wire [15:0] settleTarget = 16'((settleCode + 3'h1) * SETTLE_UNIT);
  wire [6:0] bitMask = 7'(7'h01 << bitIdx_reg);
  wire [6:0] judged = oscAboveTarget ? (trial_reg & ~bitMask) : trial_reg;
  wire lastBit = (bitIdx_reg == 3'h0);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cal_ctrl_pkg::OSC_IDLE: begin
        if (!tuneReset) state_next = tuneEnable ? cal_ctrl_pkg::OSC_STEP : cal_ctrl_pkg::OSC_DONE;
      end
      cal_ctrl_pkg::OSC_STEP: state_next = cal_ctrl_pkg::OSC_SETTLE;
      cal_ctrl_pkg::OSC_SETTLE: begin
        if (settle_reg >= settleTarget) state_next = lastBit ? cal_ctrl_pkg::OSC_DONE : cal_ctrl_pkg::OSC_STEP;
      end
      cal_ctrl_pkg::OSC_DONE: state_next = cal_ctrl_pkg::OSC_DONE;
    endcase
    if (tuneReset) state_next = cal_ctrl_pkg::OSC_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= cal_ctrl_pkg::OSC_IDLE;
      trial_reg <= `TRIM_FIRST_TRIAL;
      bitIdx_reg <= 3'(`TRIM_MSB);
      settle_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      settle_reg <= (state_reg == cal_ctrl_pkg::OSC_SETTLE) ? settle_reg + 16'h0001 : 16'h0000;
      if (state_reg == cal_ctrl_pkg::OSC_IDLE) begin
        trial_reg <= `TRIM_FIRST_TRIAL;
        bitIdx_reg <= 3'(`TRIM_MSB);
      end else if (state_reg == cal_ctrl_pkg::OSC_SETTLE && settle_reg >= settleTarget) begin
        // Keep or drop the bit under test, then try the next lower one
        trial_reg <= lastBit ? judged : (judged | (bitMask >> 1));
        bitIdx_reg <= lastBit ? bitIdx_reg : bitIdx_reg - 3'h1;
      end
    end
  end

  assign trimLoad = (state_reg == cal_ctrl_pkg::OSC_STEP) ||
                    (state_reg == cal_ctrl_pkg::OSC_SETTLE && settle_reg >= settleTarget);
  assign trimValue = (state_reg == cal_ctrl_pkg::OSC_STEP) ? trial_reg : judged;
  assign busy = (state_reg == cal_ctrl_pkg::OSC_STEP) || (state_reg == cal_ctrl_pkg::OSC_SETTLE);
  assign finished = (state_reg == cal_ctrl_pkg::OSC_DONE);
endmodule

// file: test/testbench.sv
// Self-checking bench for the calibration control block
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, oscAboveTarget = 0;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [6:0] oscTrim, target = 0;
  logic calInReset, calValuesReset, fgCalRun, fgOffsetRun, bgCalRun, bgOffsetRun;
  logic digClkEn, linkClkEn, serialLinkEnable;
  logic [31:0] rd;
  int errors = 0, n_tests = 0, seed = 32'h7e970bd3;
  int nValRst, nFg, nFgOff, nDig, nLink, nHold;
  logic [7:0] regIdx [9] = '{8'h59, 8'h5c, 8'h5d, 8'h5e, 8'h61, 8'h62, 8'h65, 8'h70, 8'h72};
  logic [7:0] regRst [9] = '{8'h00, 8'h00, 8'h40, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [6:0] targets [3];

  adc_cal_control #(.SETTLE_UNIT(1), .FG_CYCLES(8), .OFFSET_CYCLES(4), .DIG_DIV(4), .LINK_DIV(8)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .oscAboveTarget(oscAboveTarget), .oscTrim(oscTrim),
    .calInReset(calInReset), .calValuesReset(calValuesReset), .fgCalRun(fgCalRun),
    .fgOffsetRun(fgOffsetRun), .bgCalRun(bgCalRun), .bgOffsetRun(bgOffsetRun), .digClkEn(digClkEn),
    .linkClkEn(linkClkEn), .serialLinkEnable(serialLinkEnable), .irq(irq));

  always #5 clk_sys = ~clk_sys;

  // Oscillator stand-in: above target while trim is too high
  always @(posedge clk_sys) oscAboveTarget <= (oscTrim > target);

  // Counts sampled mid-cycle, away from the launching edge
  always @(negedge clk_sys) begin
    nValRst += calValuesReset;
    nFg += fgCalRun;
    nFgOff += fgOffsetRun;
    nDig += digClkEn;
    nLink += linkClkEn;
    nHold += calInReset;
  end

  function automatic int expFg(logic [3:0] c);
    return c[0] ? 8 : 0;
  endfunction

  function automatic int expFgOff(logic [3:0] c);
    return (c[0] && c[2]) ? 4 : 0;
  endfunction

  task automatic clearCounts();
    nValRst = 0; nFg = 0; nFgOff = 0; nDig = 0; nLink = 0; nHold = 0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Handshake seen at negedge is the one taken at the next rising edge
  task automatic axiWrite(input logic [7:0] idx, input logic [7:0] val);
    logic awDone, wDone, bDone;
    awDone = 0; wDone = 0; bDone = 0;
    @(posedge clk_sys);
    awvalid <= 1; wvalid <= 1; awaddr <= {idx, 2'b00}; wdata <= {24'h0, val}; wstrb <= 4'h1; bready <= 1;
    while (!bDone) begin
      @(negedge clk_sys);
      awDone = awDone || (awvalid && awready);
      wDone = wDone || (wvalid && wready);
      bDone = bvalid;
      resp = bresp;
      @(posedge clk_sys);
      if (awDone) awvalid <= 0;
      if (wDone) wvalid <= 0;
    end
    bready <= 0;
  endtask

  task automatic axiRead(input logic [7:0] idx);
    logic aDone, rDone;
    aDone = 0; rDone = 0;
    @(posedge clk_sys);
    arvalid <= 1; araddr <= {idx, 2'b00}; rready <= 1;
    while (!rDone) begin
      @(negedge clk_sys);
      aDone = aDone || (arvalid && arready);
      rDone = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (aDone) arvalid <= 0;
    end
    rready <= 0;
  endtask

  initial begin
    #300000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 0;
    repeat (3) @(posedge clk_sys);
    // Reset values, bypassed tuning reads finished
    for (int i = 0; i < 9; i++) begin
      axiRead(regIdx[i]);
      check(rd, {24'h0, regRst[i]});
    end
    axiWrite(`IDX_OSC_STATUS, 8'hff);
    axiRead(`IDX_OSC_STATUS);
    check(rd, 32'h1);
    axiRead(8'h00);
    check(rd, 32'h0);
    check(resp, `RESP_SLVERR);
    axiWrite(8'hff, 8'h01);
    check(resp, `RESP_SLVERR);
    // Every configuration combination, reserved bits at default
    for (int c = 0; c < 16; c++) begin
      axiWrite(`IDX_LINK_ENABLE, 8'h00);
      axiWrite(`IDX_CAL_ENABLE, 8'h00);
      repeat (2) @(posedge clk_sys);
      clearCounts();
      repeat (16) @(posedge clk_sys);
      check(nHold, 32'd16);
      check(nDig, 32'd0);
      check(nLink, 32'd0);
      axiWrite(`IDX_CALIBRATION_CONFIG_0, 8'(c));
      axiWrite(`IDX_IRQ_STATUS, 8'h03);
      clearCounts();
      axiWrite(`IDX_CAL_ENABLE, 8'h01);
      repeat (40) @(posedge clk_sys);
      check(nValRst, 32'd1);
      check(nFg, 32'(expFg(4'(c))));
      check(nFgOff, 32'(expFgOff(4'(c))));
      @(negedge clk_sys);
      check({bgCalRun, bgOffsetRun}, {c[1], c[1] & c[3]});
      // Pass completion is flagged in the interrupt status
      axiRead(`IDX_IRQ_STATUS);
      check(rd, 32'h2);
      clearCounts();
      repeat (16) @(posedge clk_sys);
      check(nDig, 32'd4);
      check(nLink, 32'd2);
      check(nHold, 32'd0);
      axiWrite(`IDX_LINK_ENABLE, 8'h01);
      check(serialLinkEnable, 1'b1);
    end
    targets[0] = 7'h00;
    targets[1] = 7'h7f;
    targets[2] = 7'($random(seed));
    // Tuning runs, software keeps off the trim meanwhile
    foreach (targets[i]) begin
      target <= targets[i];
      axiWrite(`IDX_PLL_RESET, 8'h01);
      axiWrite(`IDX_OSC_CTRL, 8'h01);
      axiWrite(`IDX_IRQ_STATUS, 8'h03);
      axiWrite(`IDX_IRQ_MASK, 8'h01);
      check(irq, 1'b0);
      axiWrite(`IDX_PLL_RESET, 8'h00);
      axiRead(`IDX_OSC_STATUS);
      check(rd, 32'h0);
      for (int k = 0; k < 60 && rd !== 32'h1; k++) axiRead(`IDX_OSC_STATUS);
      check(rd, 32'h1);
      check(irq, 1'b1);
      axiRead(`IDX_OSC_TRIM);
      check(rd, {25'h0, targets[i]});
      check(oscTrim, targets[i]);
      axiWrite(`IDX_IRQ_MASK, 8'h00);
      check(irq, 1'b0);
      axiWrite(`IDX_IRQ_STATUS, 8'h01);
      axiWrite(`IDX_IRQ_MASK, 8'h01);
      check(irq, 1'b0);
    end
    // Bypassed tuning also reports finished, then the trim is free again
    axiWrite(`IDX_PLL_RESET, 8'h01);
    axiWrite(`IDX_OSC_CTRL, `RST_OSC_CTRL);
    axiRead(`IDX_OSC_STATUS);
    check(rd, 32'h0);
    axiWrite(`IDX_PLL_RESET, 8'h00);
    axiRead(`IDX_OSC_STATUS);
    check(rd, 32'h1);
    axiWrite(`IDX_OSC_TRIM, 8'h2a);
    axiRead(`IDX_OSC_TRIM);
    check(rd, 32'h2a);
    check(oscTrim, 7'h2a);
    complete_run();
  end
endmodule
